//--- rtl/spmc_pkg.sv
package spmc_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index).
    // ------------------------------------------------------------
    localparam int AXI_ADDR_W = 12;
    localparam logic [7:0] IDX_CAL3 = 8'h40;
    localparam logic [7:0] IDX_CAL2 = 8'h41;
    localparam logic [7:0] IDX_CAL1 = 8'h42;
    localparam logic [7:0] IDX_CAL0 = 8'h43;
    localparam logic [7:0] IDX_PRI_STAT = 8'h30;
    localparam logic [7:0] IDX_SEC_STAT = 8'h31;
    localparam logic [7:0] IDX_CTRL = 8'h32;
    localparam logic [7:0] IDX_CORE_STAT = 8'h33;

    // ------------------------------------------------------------
    // Field positions and reset values.
    // ------------------------------------------------------------
    localparam int STAT_FREQ_LSB = 3;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_LIMIT_BIT = 0;
    localparam int CTRL_MODE_LO_BIT = 0;
    localparam int CTRL_MODE_HI_BIT = 1;
    localparam int CTRL_REF_BIT = 2;
    localparam int CTRL_ARD_BIT = 3;
    localparam int CTRL_RELEASE_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h02;
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam int CORE_LOCK_BIT = 0;
    localparam int CORE_HOLD_BIT = 1;
    localparam int CORE_FREE_BIT = 2;

    // ------------------------------------------------------------
    // Encodings and qualification counts.
    // ------------------------------------------------------------
    localparam logic [1:0] FREQ_19M44 = 2'h0;
    localparam logic [1:0] FREQ_8K = 2'h1;
    localparam logic [1:0] FREQ_1M544 = 2'h2;
    localparam logic [1:0] FREQ_2M048 = 2'h3;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_HOLDOVER = 2'h1;
    localparam int QUAL_W = 10;
    localparam logic [9:0] QUAL_T1E1 = 10'h040;
    localparam logic [9:0] QUAL_19M44 = 10'h200;
    localparam logic [9:0] QUAL_8K = 10'h001;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_FREERUN,
        ST_HOLD_MANUAL,
        ST_ACQUIRE,
        ST_NORMAL,
        ST_AUTO_HOLD
    } spmc_state_type;

endpackage : spmc_pkg

//--- rtl/spmc_mode_ctrl.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Status bits 4-3 give the secondary reference frequency code.
// - Status bit 1 high while the secondary acquisition loop is in holdover.
// - Status bit 0 high while the secondary loop exceeds its capture range.
// - Calibration word is four RW byte registers at indices 0x40-0x43, reset zero.
// - Normal selected: pass through holdover, acquire, then normal; else wait.
// - Holdover without prior lock keeps free-run accuracy on the core.
// - Valid reference clears acquisition holdover; core then locks to normal alone.
// - Normal mode drives the lock status bit and the lock pin high.
// - Frequency offset beyond 30000 ppm declares reference failure.
// - Phase hit over half a cycle fails the reference, except at 8 kHz.
// - Failure in normal forces auto holdover: lock low, holdover high.
// - Auto return after 64, 512 or 1 clean reference cycles when enabled.
// - With auto return disabled, a rising manual release returns to normal.
// - A release edge while the reference is still bad is ignored.
// - Return to normal is hitless: core realigns phase instead of jumping.
// - Changing the reference in normal passes through holdover and relocks.
module spmc_mode_ctrl #(
    parameter int LOCK_CYCLES = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] ref_clk,
    input wire logic [1:0] ref_lost,
    input wire logic [1:0] ref_freq_bad,
    input wire logic [1:0] ref_phase_hit,
    input wire logic [1:0] ref_capture_exceed,
    input wire logic [3:0] ref_freq_code,
    output logic lock_out,
    output logic holdover_out,
    output logic freerun_out,
    output logic core_track,
    output logic core_freerun_accuracy,
    output logic core_ref_sel,
    output logic phase_realign,
    output logic [31:0] mclk_freq_cal
);

    // The lock counter is 16 bits wide, so longer lock times cannot be served.
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 65535)
    begin : g_bad_lock
        $error("LOCK_CYCLES must be within 1 to 65535.");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Clean reference cycles needed before the loop leaves holdover.
    function automatic logic [9:0] qual_count(input logic [1:0] code);
        case (code)
            spmc_pkg::FREQ_8K: qual_count = spmc_pkg::QUAL_8K;
            spmc_pkg::FREQ_19M44: qual_count = spmc_pkg::QUAL_19M44;
            default: qual_count = spmc_pkg::QUAL_T1E1;
        endcase
    endfunction : qual_count

    // Index of a word address, or all ones when it lies outside the map.
    function automatic logic [8:0] word_index(input logic [11:0] addr);
        word_index = (addr[11:10] == 2'h0) ? {1'b0, addr[9:2]} : 9'h1ff;
    endfunction : word_index

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [13:0] sync_a;
    logic [13:0] sync_b;
    logic [1:0] clk_prev;
    logic [13:0] next_sync_a;
    logic [13:0] next_sync_b;
    logic [1:0] next_clk_prev;

    // Every reference pin is asynchronous; only the second stage is read.
    always_comb
    begin
        next_sync_a = {ref_freq_code, ref_capture_exceed, ref_phase_hit,
                       ref_freq_bad, ref_lost, ref_clk};
        next_sync_b = sync_a;
        next_clk_prev = sync_b[1:0];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_a <= 14'h0000;
            sync_b <= 14'h0000;
            clk_prev <= 2'h0;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
            clk_prev <= next_clk_prev;
        end
    end

    logic [1:0] clk_s;
    logic [1:0] lost_s;
    logic [1:0] bad_s;
    logic [1:0] hit_s;
    logic [1:0] limit_s;
    logic [3:0] code_s;
    assign clk_s = sync_b[1:0];
    assign lost_s = sync_b[3:2];
    assign bad_s = sync_b[5:4];
    assign hit_s = sync_b[7:6];
    assign limit_s = sync_b[9:8];
    assign code_s = sync_b[13:10];

    // ------------------------------------------------------------
    // Acquisition loop holdover tracking, one per reference
    // ------------------------------------------------------------
    logic [1:0] acq_hold;
    logic [9:0] qual_cnt [2];
    logic [1:0] next_acq_hold;
    logic [9:0] next_qual_cnt [2];

    // Sampling at 40 MHz sees a 19.44 MHz reference only marginally,
    // so its clean-cycle count is a lower bound, never an overcount.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            next_acq_hold[i] = acq_hold[i];
            next_qual_cnt[i] = qual_cnt[i];
            if (lost_s[i] || bad_s[i] ||
                (hit_s[i] && code_s[2*i +: 2] != spmc_pkg::FREQ_8K))
            begin
                next_acq_hold[i] = 1'b1;
                next_qual_cnt[i] = 10'h000;
            end
            else if (acq_hold[i] && clk_s[i] && !clk_prev[i])
            begin
                if (qual_cnt[i] + 10'h001 >= qual_count(code_s[2*i +: 2]))
                begin
                    next_acq_hold[i] = 1'b0;
                    next_qual_cnt[i] = 10'h000;
                end
                else
                begin
                    next_qual_cnt[i] = qual_cnt[i] + 10'h001;
                end
            end
        end
    end

    // Loops start in holdover: nothing has been acquired after reset.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acq_hold <= 2'h3;
            qual_cnt[0] <= 10'h000;
            qual_cnt[1] <= 10'h000;
        end
        else
        begin
            acq_hold <= next_acq_hold;
            qual_cnt[0] <= next_qual_cnt[0];
            qual_cnt[1] <= next_qual_cnt[1];
        end
    end

    // ------------------------------------------------------------
    // Core mode state machine
    // ------------------------------------------------------------
    logic [4:0] ctrl;
    logic [1:0] mode_sel;
    logic ref_choice;
    logic auto_return_disable;
    logic manual_hold_release;
    assign mode_sel = {ctrl[spmc_pkg::CTRL_MODE_HI_BIT], ctrl[spmc_pkg::CTRL_MODE_LO_BIT]};
    assign ref_choice = ctrl[spmc_pkg::CTRL_REF_BIT];
    assign auto_return_disable = ctrl[spmc_pkg::CTRL_ARD_BIT];
    assign manual_hold_release = ctrl[spmc_pkg::CTRL_RELEASE_BIT];

    spmc_pkg::spmc_state_type state;
    spmc_pkg::spmc_state_type next_state;
    logic [15:0] lock_cnt;
    logic [15:0] next_lock_cnt;
    logic release_prev;
    logic ref_prev;
    logic ever_locked;
    logic next_ever_locked;
    logic next_realign;
    logic act_hold;
    logic release_rise;
    assign act_hold = acq_hold[ref_choice];
    assign release_rise = manual_hold_release && !release_prev;

    // Mode transitions; codes other than normal and holdover mean free-run.
    always_comb
    begin
        next_state = state;
        next_lock_cnt = lock_cnt;
        next_realign = 1'b0;
        next_ever_locked = ever_locked;
        if (mode_sel == spmc_pkg::MODE_HOLDOVER)
        begin
            next_state = spmc_pkg::ST_HOLD_MANUAL;
        end
        else if (mode_sel != spmc_pkg::MODE_NORMAL)
        begin
            next_state = spmc_pkg::ST_FREERUN;
        end
        else
        begin
            case (state)
                spmc_pkg::ST_FREERUN, spmc_pkg::ST_HOLD_MANUAL:
                begin
                    next_state = spmc_pkg::ST_ACQUIRE;
                    next_lock_cnt = 16'h0000;
                end
                spmc_pkg::ST_ACQUIRE:
                begin
                    if (act_hold || ref_choice != ref_prev)
                    begin
                        next_lock_cnt = 16'h0000;
                    end
                    else if (lock_cnt == 16'(LOCK_CYCLES - 1))
                    begin
                        next_state = spmc_pkg::ST_NORMAL;
                        next_realign = 1'b1;
                        next_ever_locked = 1'b1;
                    end
                    else
                    begin
                        next_lock_cnt = lock_cnt + 16'h0001;
                    end
                end
                spmc_pkg::ST_NORMAL:
                begin
                    if (ref_choice != ref_prev)
                    begin
                        next_state = spmc_pkg::ST_ACQUIRE;
                        next_lock_cnt = 16'h0000;
                    end
                    else if (act_hold)
                    begin
                        next_state = spmc_pkg::ST_AUTO_HOLD;
                    end
                end
                spmc_pkg::ST_AUTO_HOLD:
                begin
                    if (ref_choice != ref_prev)
                    begin
                        next_state = spmc_pkg::ST_ACQUIRE;
                        next_lock_cnt = 16'h0000;
                    end
                    else if (!act_hold && (!auto_return_disable || release_rise))
                    begin
                        next_state = spmc_pkg::ST_NORMAL;
                        next_realign = 1'b1;
                    end
                end
                default:
                begin
                    next_state = spmc_pkg::ST_FREERUN;
                end
            endcase
        end
    end

    // Outputs are registered from the next state so they change together.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= spmc_pkg::ST_FREERUN;
            lock_cnt <= 16'h0000;
            release_prev <= 1'b0;
            ref_prev <= 1'b0;
            ever_locked <= 1'b0;
            lock_out <= 1'b0;
            holdover_out <= 1'b0;
            freerun_out <= 1'b1;
            core_track <= 1'b0;
            core_freerun_accuracy <= 1'b1;
            core_ref_sel <= 1'b0;
            phase_realign <= 1'b0;
        end
        else
        begin
            state <= next_state;
            lock_cnt <= next_lock_cnt;
            release_prev <= manual_hold_release;
            ref_prev <= ref_choice;
            ever_locked <= next_ever_locked;
            lock_out <= (next_state == spmc_pkg::ST_NORMAL);
            holdover_out <= (next_state == spmc_pkg::ST_HOLD_MANUAL ||
                             next_state == spmc_pkg::ST_ACQUIRE ||
                             next_state == spmc_pkg::ST_AUTO_HOLD);
            freerun_out <= (next_state == spmc_pkg::ST_FREERUN);
            core_track <= (next_state == spmc_pkg::ST_NORMAL);
            core_freerun_accuracy <= !next_ever_locked;
            core_ref_sel <= ref_choice;
            phase_realign <= next_realign;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite register slave
    // ------------------------------------------------------------
    logic aw_pend;
    logic w_pend;
    logic [8:0] aw_idx;
    logic [7:0] w_byte;
    logic w_lane0;
    logic [31:0] cal;
    logic next_aw_pend;
    logic next_w_pend;
    logic [8:0] next_aw_idx;
    logic [7:0] next_w_byte;
    logic next_w_lane0;
    logic [31:0] next_cal;
    logic [4:0] next_ctrl;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic [7:0] pri_stat;
    logic [7:0] sec_stat;
    logic [7:0] core_stat;
    logic [8:0] ar_idx;

    assign s_axi_awready = !aw_pend && !s_axi_bvalid;
    assign s_axi_wready = !w_pend && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign mclk_freq_cal = cal;
    assign ar_idx = word_index(s_axi_araddr);

    // live status, no read side effects
    assign pri_stat = {3'h0, code_s[1:0], 1'b0, acq_hold[0], limit_s[0]};
    assign sec_stat = {3'h0, code_s[3:2], 1'b0, acq_hold[1], limit_s[1]};
    assign core_stat = {5'h00, freerun_out, holdover_out, lock_out};

    // Address and data are latched separately so either may come first.
    always_comb
    begin
        next_aw_pend = aw_pend;
        next_w_pend = w_pend;
        next_aw_idx = aw_idx;
        next_w_byte = w_byte;
        next_w_lane0 = w_lane0;
        next_cal = cal;
        next_ctrl = ctrl;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_pend = 1'b1;
            next_aw_idx = word_index(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_pend = 1'b1;
            next_w_byte = s_axi_wdata[7:0];
            next_w_lane0 = s_axi_wstrb[0];
        end
        if (aw_pend && w_pend)
        begin
            next_aw_pend = 1'b0;
            next_w_pend = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = spmc_pkg::RESP_OKAY;
            case (aw_idx)
                {1'b0, spmc_pkg::IDX_CAL3}: if (w_lane0) next_cal[31:24] = w_byte;
                {1'b0, spmc_pkg::IDX_CAL2}: if (w_lane0) next_cal[23:16] = w_byte;
                {1'b0, spmc_pkg::IDX_CAL1}: if (w_lane0) next_cal[15:8] = w_byte;
                {1'b0, spmc_pkg::IDX_CAL0}: if (w_lane0) next_cal[7:0] = w_byte;
                // software owns mode and release bits
                {1'b0, spmc_pkg::IDX_CTRL}: if (w_lane0) next_ctrl = w_byte[4:0];
                {1'b0, spmc_pkg::IDX_PRI_STAT}, {1'b0, spmc_pkg::IDX_SEC_STAT},
                {1'b0, spmc_pkg::IDX_CORE_STAT}: next_bresp = spmc_pkg::RESP_OKAY;
                default: next_bresp = spmc_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = spmc_pkg::RESP_OKAY;
            next_rdata = 32'h00000000;
            case (ar_idx)
                {1'b0, spmc_pkg::IDX_CAL3}: next_rdata[7:0] = cal[31:24];
                {1'b0, spmc_pkg::IDX_CAL2}: next_rdata[7:0] = cal[23:16];
                {1'b0, spmc_pkg::IDX_CAL1}: next_rdata[7:0] = cal[15:8];
                {1'b0, spmc_pkg::IDX_CAL0}: next_rdata[7:0] = cal[7:0];
                {1'b0, spmc_pkg::IDX_CTRL}: next_rdata[4:0] = ctrl;
                {1'b0, spmc_pkg::IDX_PRI_STAT}: next_rdata[7:0] = pri_stat;
                {1'b0, spmc_pkg::IDX_SEC_STAT}: next_rdata[7:0] = sec_stat;
                {1'b0, spmc_pkg::IDX_CORE_STAT}: next_rdata[7:0] = core_stat;
                default: next_rresp = spmc_pkg::RESP_SLVERR;
            endcase
        end
    end

    // Control resets to free-run so the core idles until software is ready.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_pend <= 1'b0;
            w_pend <= 1'b0;
            aw_idx <= 9'h000;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
            cal <= {4{spmc_pkg::CAL_RESET}};
            ctrl <= spmc_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            aw_pend <= next_aw_pend;
            w_pend <= next_w_pend;
            aw_idx <= next_aw_idx;
            w_byte <= next_w_byte;
            w_lane0 <= next_w_lane0;
            cal <= next_cal;
            ctrl <= next_ctrl;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule : spmc_mode_ctrl

//--- testbench/spmc_ref_model.sv
`timescale 1ns/1ps
module spmc_ref_model (
    input wire logic aclk,
    input wire logic [1:0] lost_req,
    output logic [1:0] ref_clk,
    output logic [1:0] ref_lost
);
    logic [2:0] div = 3'h0;
    logic [1:0] ph = 2'h0;
    assign ref_clk = ph;
    // lost source stops
    // A lost source stops toggling, as a cut cable would, and flags it.
    always_ff @(posedge aclk)
    begin
        div <= div + 3'h1;
        ref_lost <= lost_req;
        for (int i = 0; i < 2; i++)
            if (div == 3'h7 && !lost_req[i]) ph[i] <= !ph[i];
    end
endmodule : spmc_ref_model

//--- testbench/spmc_mode_ctrl_assertions.sv
`timescale 1ns/1ps
module spmc_mode_ctrl_assertions (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] ref_lost,
    input wire logic lock_out,
    input wire logic holdover_out,
    input wire logic freerun_out,
    input wire logic core_track,
    input wire logic core_freerun_accuracy,
    input wire logic core_ref_sel,
    input wire logic phase_realign
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Lock rises in one step.
    sequence s_lock_up;
        !lock_out ##1 lock_out;
    endsequence
    // The source in use is lost while locked; two sync flops lie in the path.
    sequence s_fail;
        lock_out && ref_lost[core_ref_sel];
    endsequence
    lock_excl_a: assert property (lock_out |-> !holdover_out && !freerun_out)
        else $error("lock with other mode");
    track_lock_a: assert property (core_track == lock_out)
        else $error("track differs from lock");
    realign_rise_a: assert property (s_lock_up |-> phase_realign)
        else $error("no realign at lock");
    realign_only_a: assert property (phase_realign |-> lock_out && !$past(lock_out))
        else $error("stray realign");
    fail_hold_a: assert property (s_fail |-> ##[1:6] holdover_out)
        else $error("no auto holdover");
    acc_clear_a: assert property (lock_out |=> !core_freerun_accuracy)
        else $error("accuracy flag stuck");
    acc_keep_a: assert property ($fell(core_freerun_accuracy) |-> lock_out)
        else $error("accuracy flag fell early");
    free_excl_a: assert property (freerun_out |-> !holdover_out && !core_track)
        else $error("free-run with other mode");
endmodule : spmc_mode_ctrl_assertions
bind spmc_mode_ctrl spmc_mode_ctrl_assertions u_chk (.*);

//--- testbench/sync_pll_mode_control_tb_top.sv
`timescale 1ns/1ps
module sync_pll_mode_control_tb_top;
    logic aclk, aresetn, saw_hold;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, lock_out, holdover_out, freerun_out;
    logic core_track, core_freerun_accuracy, core_ref_sel, phase_realign;
    logic [31:0] s_axi_wdata, s_axi_rdata, mclk_freq_cal, d;
    logic [3:0] s_axi_wstrb, ref_freq_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, ref_clk, ref_lost, ref_freq_bad;
    logic [1:0] ref_phase_hit, ref_capture_exceed, lost_req, r, fc;
    logic [7:0] cal [4];
    int n_fail = 0;
    int samples_checked = 0;
    int n_realign = 0;
    spmc_mode_ctrl #(.LOCK_CYCLES(4)) DUT (.*);
    spmc_ref_model u_ref (.aclk(aclk), .lost_req(lost_req), .ref_clk(ref_clk), .ref_lost(ref_lost));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : settle
    // Waits for normal (1) or holdover (0); a timeout shows up in the next compare.
    task automatic wait_st(input logic l);
        for (int n = 0; n < 4000 && !(lock_out === l && holdover_out === !l); n++)
            @(negedge aclk);
        settle(1);
    endtask : wait_st
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic aw_p, w_p;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        aw_p = 1'b1;
        w_p = 1'b1;
        while (aw_p || w_p)
        begin
            @(negedge aclk);
            aw_p = aw_p && !s_axi_awready;
            w_p = w_p && !s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= aw_p;
            s_axi_wvalid <= w_p;
        end
        do @(negedge aclk); while (!s_axi_bvalid);
        chk("bresp", s_axi_bresp, spmc_pkg::RESP_OKAY);
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial
    begin
        aclk = 1'b0;
        forever #12.5 aclk = !aclk;
    end
    // Remembers any holdover pass, however brief, and counts realign pulses.
    always @(negedge aclk)
    begin
        if (holdover_out === 1'b1) saw_hold = 1'b1;
        if (phase_realign === 1'b1) n_realign++;
    end
    initial
    begin
        repeat (20000) @(posedge aclk);
        n_fail++;
        stop_test();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        ref_freq_code = 4'h5;
        {ref_freq_bad, ref_phase_hit, ref_capture_exceed} = 6'h00;
        lost_req = 2'h1;
        void'($urandom(25));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        settle(0);
        chk("rst", {freerun_out, holdover_out, lock_out, core_freerun_accuracy}, 4'h9);
        for (int i = 0; i < 4; i++)
        begin
            rd(12'h100 + 12'(4 * i));
            chk("cal rst", d, 32'h0);
            cal[i] = 8'($urandom);
            wr(12'h100 + 12'(4 * i), cal[i]);
        end
        settle(0);
        chk("cal word", mclk_freq_cal, {cal[0], cal[1], cal[2], cal[3]});
        for (int i = 0; i < 4; i++)
        begin
            rd(12'h100 + 12'(4 * i));
            chk("cal rd", d, {24'h0, cal[i]});
        end
        rd(12'h800);
        chk("unmapped", r, spmc_pkg::RESP_SLVERR);
        $display("end of register test");
        wr(12'hc8, 8'h00);
        settle(40);
        chk("no ref", {lock_out, holdover_out, core_freerun_accuracy}, 3'h3);
        @(posedge aclk);
        lost_req <= 2'h0;
        wait_st(1'b1);
        chk("start", {lock_out, holdover_out, core_freerun_accuracy, core_track}, 4'h9);
        @(posedge aclk);
        ref_freq_bad <= 2'h1;
        wait_st(1'b0);
        chk("freq fail", {lock_out, holdover_out, core_track}, 3'h2);
        @(posedge aclk);
        ref_freq_bad <= 2'h0;
        wait_st(1'b1);
        chk("return", {lock_out, holdover_out}, 2'h2);
        @(posedge aclk);
        ref_phase_hit <= 2'h1;
        settle(40);
        chk("8k hit", lock_out, 1'b1);
        @(posedge aclk);
        ref_freq_code <= 4'h7;
        wait_st(1'b0);
        chk("hit fail", {lock_out, holdover_out}, 2'h1);
        @(posedge aclk);
        ref_phase_hit <= 2'h0;
        settle(990);
        chk("64 edges", {lock_out, holdover_out}, 2'h1);
        wait_st(1'b1);
        chk("return 64", {lock_out, holdover_out}, 2'h2);
        $display("end of mode test");
        wr(12'hc8, 8'h08);
        lost_req <= 2'h1;
        wait_st(1'b0);
        wr(12'hc8, 8'h18);
        wr(12'hc8, 8'h08);
        lost_req <= 2'h0;
        settle(1500);
        chk("held", {lock_out, holdover_out}, 2'h1);
        wr(12'hc8, 8'h18);
        wr(12'hc8, 8'h08);
        wait_st(1'b1);
        chk("release", {lock_out, holdover_out}, 2'h2);
        saw_hold = 1'b0;
        wr(12'hc8, 8'h04);
        settle(3);
        wait_st(1'b1);
        chk("ref switch", {saw_hold, core_ref_sel, lock_out}, 3'h7);
        wr(12'hc8, 8'h05);
        settle(2);
        chk("manual", {lock_out, holdover_out, freerun_out}, 3'h2);
        wr(12'hc8, 8'h04);
        wait_st(1'b1);
        $display("end of release test");
        fc = 2'($urandom);
        @(posedge aclk);
        ref_freq_code <= {fc, 2'h3};
        ref_capture_exceed <= 2'h2;
        lost_req <= 2'h2;
        settle(10);
        for (int i = 0; i < 2; i++)
        begin
            rd(12'hc4);
            chk("sec stat", d, {27'h0, fc, 3'h3});
        end
        rd(12'hcc);
        chk("core stat", d, 32'h2);
        rd(12'hc0);
        chk("pri stat", d, 32'h18);
        ref_capture_exceed <= 2'h0;
        settle(4);
        rd(12'hc4);
        chk("sec limit", d[0], 1'b0);
        chk("realigns", n_realign, 6);
        $display("end of status test");
        stop_test();
    end
endmodule : sync_pll_mode_control_tb_top
